// ---- core/sdram_init_sequencer.sv ----
// Host sequencer that powers up an SDRAM through the memory controller registers
`timescale 1ns/1ps
// Operation
// - Hold clock enable high, buffers off, controller on
// - Wait 100 ms after power and clocks
// - First select NOP init command
// - Then select precharge-all init command
// - Let at least two refresh cycles elapse
// - Operational refresh is period/rows times clock/16
// - Write refresh, then latency, then configuration
// - Select mode command, then one SDRAM read
// - Return init command to normal
// - Enable buffers last; row-bank-column config 0x00280 then 0x80283
// - Mode value 0x23: burst 8, CAS 2
// - Row-bank-column offset is mode shifted 10..17
// - Mode read at SDRAM base plus offset
// - Low-power SDRAM uses bank-row-column mapping
// - Bank-row-column offset is mode shifted 9..16
module sdram_init_sequencer #(
    parameter int POWERUP_COUNT = sdram_init_pkg::POWERUP_CYCLES,
    parameter int TIMER_WIDTH   = 24
) (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     start,
    input  wire logic                     bank_row_col_map,
    input  wire logic [2:0]               size_shift,
    input  wire logic [15:0]              refresh_value,
    input  wire logic [15:0]              ras_cas_value,
    output sdram_init_pkg::mem_req_s      req,
    input  wire logic                     ack,
    output logic                          busy,
    output logic                          done,
    output logic                          ce_forced
);
    // Refused at elaboration: a count that overflows the timer would wrap early
    if (POWERUP_COUNT >= (1 << TIMER_WIDTH) || POWERUP_COUNT < 1 ||
        TIMER_WIDTH > 31) begin : g_bad_powerup
        $error("sdram_init_sequencer: POWERUP_COUNT does not fit the timer");
    end

    localparam int REFWAIT_CYCLES =
        sdram_init_pkg::REFRESH_CLKS * (sdram_init_pkg::MIN_REFRESHES + 1);

    sdram_init_pkg::init_state_e state_reg, state_next;
    logic [2:0]                  step_reg, step_next;
    sdram_init_pkg::mem_req_s    req_reg, req_next;
    logic                        done_reg, done_next;
    logic                        ce_reg, ce_next;
    logic                        tmr_load;
    logic [TIMER_WIDTH-1:0]      tmr_count;
    logic                        tmr_expired;
    logic [31:0]                 cfg_base;
    logic [31:0]                 mode_offset;
    logic [4:0]                  shift_amt;

    init_wait_timer #(.WIDTH(TIMER_WIDTH)) u_timer (
        .clock   (clock),
        .rst     (rst),
        .load    (tmr_load),
        .count   (tmr_count),
        .expired (tmr_expired)
    );

    // Mapping choice only changes the config word and mode read offset
    always_comb begin
        if (bank_row_col_map) begin
            cfg_base  = sdram_init_pkg::CFG_ROW_MAP | sdram_init_pkg::CFG_BANK_MAP_BIT;
            shift_amt = 5'(sdram_init_pkg::BANK_SHIFT_MIN) + {2'h0, size_shift};
        end else begin
            cfg_base  = sdram_init_pkg::CFG_ROW_MAP;
            shift_amt = 5'(sdram_init_pkg::ROW_SHIFT_MIN) + {2'h0, size_shift};
        end
        mode_offset = {24'h0, sdram_init_pkg::MODE_VALUE} << shift_amt;
    end

    function automatic sdram_init_pkg::mem_req_s wr(input logic [11:0] ofs,
                                                    input logic [31:0] val);
        sdram_init_pkg::mem_req_s r;
        r.valid = 1'b1;
        r.write = 1'b1;
        r.addr  = {20'h0, ofs};
        r.data  = val;
        return r;
    endfunction

    always_comb begin
        state_next = state_reg;
        step_next  = step_reg;
        req_next   = req_reg;
        done_next  = done_reg;
        ce_next    = ce_reg;
        tmr_load   = 1'b0;
        tmr_count  = TIMER_WIDTH'(sdram_init_pkg::SETTLE_CYCLES);
        if (req_reg.valid && ack) begin
            req_next.valid = 1'b0;
        end
        unique case (state_reg)
            sdram_init_pkg::ST_IDLE: begin
                if (start) begin
                    done_next  = 1'b0;
                    ce_next    = 1'b1;
                    step_next  = 3'h0;
                    state_next = sdram_init_pkg::ST_SETUP;
                end
            end
            sdram_init_pkg::ST_SETUP: begin
                // Four writes: control, config, dyn control CE high, buffers off
                if (!req_reg.valid) begin
                    unique case (step_reg)
                        3'h0: req_next = wr(sdram_init_pkg::CONTROL_OFS,
                                            sdram_init_pkg::CONTROL_ENABLE);
                        3'h1: req_next = wr(sdram_init_pkg::CONFIG_OFS,
                                            sdram_init_pkg::CONFIG_NORMAL);
                        3'h2: req_next = wr(sdram_init_pkg::DYN_CONTROL_OFS,
                                            sdram_init_pkg::DYN_CE_HIGH);
                        3'h3: req_next = wr(sdram_init_pkg::DYN_CFG_OFS,
                                            sdram_init_pkg::CFG_BUF_OFF);
                        default: begin
                            tmr_load   = 1'b1;
                            tmr_count  = TIMER_WIDTH'(POWERUP_COUNT);
                            state_next = sdram_init_pkg::ST_POWERUP;
                        end
                    endcase
                    step_next = step_reg + 3'h1;
                end
            end
            sdram_init_pkg::ST_POWERUP: begin
                if (tmr_expired) begin
                    req_next   = wr(sdram_init_pkg::DYN_CONTROL_OFS,
                                    sdram_init_pkg::DYN_NOP);
                    state_next = sdram_init_pkg::ST_NOP;
                end
            end
            sdram_init_pkg::ST_NOP: begin
                if (!req_reg.valid) begin
                    req_next   = wr(sdram_init_pkg::DYN_CONTROL_OFS,
                                    sdram_init_pkg::DYN_PRECHARGE);
                    state_next = sdram_init_pkg::ST_PRECHG;
                end
            end
            sdram_init_pkg::ST_PRECHG: begin
                if (!req_reg.valid) begin
                    req_next   = wr(sdram_init_pkg::DYN_REFRESH_OFS,
                                    sdram_init_pkg::REFRESH_MIN);
                    state_next = sdram_init_pkg::ST_REFMIN;
                end
            end
            sdram_init_pkg::ST_REFMIN: begin
                if (!req_reg.valid) begin
                    tmr_load   = 1'b1;
                    tmr_count  = TIMER_WIDTH'(REFWAIT_CYCLES);
                    state_next = sdram_init_pkg::ST_REFWAIT;
                end
            end
            sdram_init_pkg::ST_REFWAIT: begin
                if (tmr_expired) begin
                    // Value is precomputed by the user as period/rows*clock/16
                    req_next   = wr(sdram_init_pkg::DYN_REFRESH_OFS,
                                    {16'h0, refresh_value});
                    state_next = sdram_init_pkg::ST_REFOP;
                end
            end
            sdram_init_pkg::ST_REFOP: begin
                if (!req_reg.valid) begin
                    req_next   = wr(sdram_init_pkg::RAS_CAS_OFS,
                                    {16'h0, ras_cas_value});
                    state_next = sdram_init_pkg::ST_LATENCY;
                end
            end
            sdram_init_pkg::ST_LATENCY: begin
                if (!req_reg.valid) begin
                    req_next   = wr(sdram_init_pkg::DYN_CFG_OFS, cfg_base);
                    state_next = sdram_init_pkg::ST_CONFIG;
                end
            end
            sdram_init_pkg::ST_CONFIG: begin
                if (!req_reg.valid) begin
                    req_next   = wr(sdram_init_pkg::DYN_CONTROL_OFS,
                                    sdram_init_pkg::DYN_MODE);
                    state_next = sdram_init_pkg::ST_MODE;
                end
            end
            sdram_init_pkg::ST_MODE: begin
                if (!req_reg.valid) begin
                    // Read data is ignored; the address carries the mode word
                    req_next.valid = 1'b1;
                    req_next.write = 1'b0;
                    req_next.addr  = sdram_init_pkg::SDRAM_BASE + mode_offset;
                    req_next.data  = 32'h0;
                    state_next     = sdram_init_pkg::ST_MODERD;
                end
            end
            sdram_init_pkg::ST_MODERD: begin
                if (!req_reg.valid) begin
                    req_next   = wr(sdram_init_pkg::DYN_CONTROL_OFS,
                                    sdram_init_pkg::DYN_NORMAL);
                    ce_next    = 1'b0;
                    state_next = sdram_init_pkg::ST_NORMAL;
                end
            end
            sdram_init_pkg::ST_NORMAL: begin
                if (!req_reg.valid) begin
                    req_next   = wr(sdram_init_pkg::DYN_CFG_OFS,
                                    cfg_base | sdram_init_pkg::CFG_BUF_EN_BIT |
                                    sdram_init_pkg::CFG_LOW_BITS);
                    state_next = sdram_init_pkg::ST_BUFEN;
                end
            end
            sdram_init_pkg::ST_BUFEN: begin
                if (!req_reg.valid) begin
                    done_next  = 1'b1;
                    state_next = sdram_init_pkg::ST_DONE;
                end
            end
            sdram_init_pkg::ST_DONE: begin
                if (start) begin
                    done_next  = 1'b0;
                    ce_next    = 1'b1;
                    step_next  = 3'h0;
                    state_next = sdram_init_pkg::ST_SETUP;
                end
            end
            default: state_next = sdram_init_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= sdram_init_pkg::ST_IDLE;
            step_reg  <= 3'h0;
            req_reg   <= '0;
            done_reg  <= 1'b0;
            ce_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            step_reg  <= step_next;
            req_reg   <= req_next;
            done_reg  <= done_next;
            ce_reg    <= ce_next;
        end
    end

    assign req       = req_reg;
    assign busy      = (state_reg != sdram_init_pkg::ST_IDLE) &&
                       (state_reg != sdram_init_pkg::ST_DONE);
    assign done      = done_reg;
    assign ce_forced = ce_reg;

    sequence s_precharge_issued;
        req.valid && req.write && req.data == sdram_init_pkg::DYN_PRECHARGE;
    endsequence

    AST_NOP_BEFORE_PRECHARGE: assert property (@(posedge clock) disable iff (rst)
        s_precharge_issued |-> $past(state_reg) == sdram_init_pkg::ST_NOP ||
                          $past(req.valid))
        else $error("precharge issued without NOP step");

    AST_REFWAIT_LEN: assert property (@(posedge clock) disable iff (rst)
        $rose(state_reg == sdram_init_pkg::ST_REFWAIT) |->
            !(state_reg == sdram_init_pkg::ST_REFOP)[*8])
        else $error("refresh wait too short");

    AST_MODE_READ_ADDR: assert property (@(posedge clock) disable iff (rst)
        (req.valid && !req.write) |-> req.addr == sdram_init_pkg::SDRAM_BASE + mode_offset)
        else $error("mode read address wrong");

    AST_MODE_AFTER_CMD: assert property (@(posedge clock) disable iff (rst)
        $rose(req.valid && !req.write) |-> $past(state_reg) == sdram_init_pkg::ST_MODE)
        else $error("mode read without mode command");

    AST_CE_DURING_INIT: assert property (@(posedge clock) disable iff (rst)
        (state_reg inside {sdram_init_pkg::ST_POWERUP, sdram_init_pkg::ST_PRECHG,
                           sdram_init_pkg::ST_MODE}) |-> ce_forced)
        else $error("clock enable not forced during init");

    AST_DONE_LAST: assert property (@(posedge clock) disable iff (rst)
        $rose(done) |-> $past(state_reg) == sdram_init_pkg::ST_BUFEN)
        else $error("done before buffer enable");

    AST_REQ_HOLD: assert property (@(posedge clock) disable iff (rst)
        (req.valid && !ack) |=> req.valid && $stable(req.addr) && $stable(req.data))
        else $error("request dropped before ack");

    AST_POWERUP_FIRST: assert property (@(posedge clock) disable iff (rst)
        (state_reg == sdram_init_pkg::ST_POWERUP && !tmr_expired) |-> !req.valid ||
            req.data != sdram_init_pkg::DYN_NOP)
        else $error("NOP before power-up wait ended");

endmodule // sdram_init_sequencer

// ---- pkg/sdram_init_pkg.sv ----
// Constants and carrier types for the SDRAM initialization host sequencer
package sdram_init_pkg;

    // Register offsets of the memory controller seen by the host
    localparam logic [11:0] CONTROL_OFS      = 12'h000;
    localparam logic [11:0] CONFIG_OFS       = 12'h008;
    localparam logic [11:0] DYN_CONTROL_OFS  = 12'h020;
    localparam logic [11:0] DYN_REFRESH_OFS  = 12'h024;
    localparam logic [11:0] DYN_CFG_OFS      = 12'h100;
    localparam logic [11:0] RAS_CAS_OFS      = 12'h104;

    // Values written during the sequence
    localparam logic [31:0] CONTROL_ENABLE   = 32'h0000_0001;
    localparam logic [31:0] CONFIG_NORMAL    = 32'h0000_0000;
    localparam logic [31:0] DYN_CE_HIGH      = 32'h0000_0007;
    localparam logic [31:0] DYN_NOP          = 32'h0000_0183;
    localparam logic [31:0] DYN_PRECHARGE    = 32'h0000_0103;
    localparam logic [31:0] DYN_MODE         = 32'h0000_0083;
    localparam logic [31:0] DYN_NORMAL       = 32'h0000_0000;
    localparam logic [31:0] REFRESH_MIN      = 32'h0000_0001;
    localparam logic [31:0] CFG_BUF_OFF      = 32'h0000_0000;
    localparam logic [31:0] CFG_ROW_MAP      = 32'h0000_0280;
    localparam logic [31:0] CFG_ROW_MAP_ON   = 32'h0008_0283;
    localparam logic [31:0] CFG_BUF_EN_BIT   = 32'h0008_0000;
    localparam logic [31:0] CFG_LOW_BITS     = 32'h0000_0003;
    localparam logic [31:0] CFG_BANK_MAP_BIT = 32'h0000_1000;
    localparam logic [31:0] RAS_CAS_DEFAULT  = 32'h0000_0202;
    localparam logic [31:0] SDRAM_BASE       = 32'h3000_0000;

    // Mode word: burst 8, sequential, CAS 2, standard, programmed write burst
    localparam logic [7:0]  MODE_VALUE       = 8'h23;
    localparam int          REFRESH_CLKS     = 16;
    localparam int          MIN_REFRESHES    = 2;
    localparam int          ROW_SHIFT_MIN    = 10;
    localparam int          BANK_SHIFT_MIN   = 9;

    // Timing
    localparam int          CLOCK_HZ         = 50_000_000;
    localparam int          POWERUP_MS       = 100;
    localparam int          POWERUP_CYCLES   = POWERUP_MS * (CLOCK_HZ / 1000);
    localparam int          SETTLE_CYCLES    = 8;

    // One register write or SDRAM read issued to the controller
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] data;
    } mem_req_s;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_SETUP   = 4'b0001,
        ST_POWERUP = 4'b0011,
        ST_NOP     = 4'b0010,
        ST_PRECHG  = 4'b0110,
        ST_REFMIN  = 4'b0111,
        ST_REFWAIT = 4'b0101,
        ST_REFOP   = 4'b0100,
        ST_LATENCY = 4'b1100,
        ST_CONFIG  = 4'b1101,
        ST_MODE    = 4'b1111,
        ST_MODERD  = 4'b1110,
        ST_NORMAL  = 4'b1010,
        ST_BUFEN   = 4'b1011,
        ST_DONE    = 4'b1001
    } init_state_e;

endpackage

// ---- core/init_wait_timer.sv ----
// Load-and-count-down wait timer for the init sequencer
`timescale 1ns/1ps
module init_wait_timer #(
    parameter int WIDTH = 24
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  expired
);
    // A very narrow timer could not hold even the settle count
    if (WIDTH < 4) begin : g_bad_width
        $error("init_wait_timer: WIDTH too small");
    end

    logic [WIDTH-1:0] left_reg;
    logic [WIDTH-1:0] left_next;

    always_comb begin
        left_next = left_reg;
        if (load) begin
            left_next = count;
        end else if (left_reg != '0) begin
            left_next = left_reg - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            left_reg <= '0;
        end else begin
            left_reg <= left_next;
        end
    end

    assign expired = (left_reg == '0) && !load;
endmodule // init_wait_timer

// ---- tb/mem_ctrl_model.sv ----
// Behavioural memory controller answering the init sequencer
`timescale 1ns/1ps
module mem_ctrl_model (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     slow,
    input  wire sdram_init_pkg::mem_req_s req,
    output logic                          ack
);
    sdram_init_pkg::mem_req_s log_q[$];
    int                       cyc_q[$];
    int                       refs_q[$];
    int                       cycle;
    int                       refreshes;
    int                       ref_timer;
    int                       wait_cnt;
    logic [31:0]              dyn_control_reg;
    logic [31:0]              dyn_refresh_reg;
    logic [31:0]              mode_addr;

    initial cycle = 0;

    always @(posedge clock) begin
        cycle <= cycle + 1;
        if (rst) begin
            ack             <= 1'b0;
            wait_cnt        <= 0;
            refreshes       <= 0;
            ref_timer       <= 0;
            dyn_control_reg <= 32'h0000_0000;
            dyn_refresh_reg <= 32'h0000_0000;
        end else begin
            // Refresh every value times 16 clocks
            if (dyn_refresh_reg != 0 &&
                ref_timer + 1 >= int'(dyn_refresh_reg) * sdram_init_pkg::REFRESH_CLKS) begin
                ref_timer <= 0;
                refreshes <= refreshes + 1;
            end else begin
                ref_timer <= ref_timer + 1;
            end
            // Slow mode stretches each answer by three cycles
            ack <= 1'b0;
            if (req.valid && !ack) begin
                if (wait_cnt < (slow ? 3 : 0)) begin
                    wait_cnt <= wait_cnt + 1;
                end else begin
                    ack      <= 1'b1;
                    wait_cnt <= 0;
                end
            end
            if (req.valid && ack) begin
                log_q.push_back(req);
                cyc_q.push_back(cycle);
                refs_q.push_back(refreshes);
                if (req.write && req.addr[11:0] == sdram_init_pkg::DYN_CONTROL_OFS) begin
                    dyn_control_reg <= req.data;
                end
                if (req.write && req.addr[11:0] == sdram_init_pkg::DYN_REFRESH_OFS) begin
                    dyn_refresh_reg <= req.data;
                    ref_timer       <= 0;
                end
                // Read data is never returned; only the address lines matter
                if (!req.write && dyn_control_reg == sdram_init_pkg::DYN_MODE) begin
                    mode_addr <= req.addr - sdram_init_pkg::SDRAM_BASE;
                end
            end
        end
    end
endmodule // mem_ctrl_model

// ---- tb/test_sdram_init_sequencer.sv ----
// Self-checking bench for the SDRAM init sequencer against a controller model
`timescale 1ns/1ps
module test_sdram_init_sequencer;
    localparam int PWR = 20;

    logic                     clock;
    logic                     rst;
    logic                     start;
    logic                     bank_row_col_map;
    logic [2:0]               size_shift;
    logic [15:0]              refresh_value;
    logic [15:0]              ras_cas_value;
    logic                     ack;
    logic                     busy;
    logic                     done;
    logic                     ce_forced;
    logic                     slow;
    sdram_init_pkg::mem_req_s req;
    int                       err_count;
    int                       total_checks;
    logic [11:0]              exp_o[14];
    logic [31:0]              exp_d[14];

    sdram_init_sequencer #(.POWERUP_COUNT(PWR)) DUT (
        .clock            (clock),
        .rst              (rst),
        .start            (start),
        .bank_row_col_map (bank_row_col_map),
        .size_shift       (size_shift),
        .refresh_value    (refresh_value),
        .ras_cas_value    (ras_cas_value),
        .req              (req),
        .ack              (ack),
        .busy             (busy),
        .done             (done),
        .ce_forced        (ce_forced)
    );

    mem_ctrl_model M (
        .clock (clock),
        .rst   (rst),
        .slow  (slow),
        .req   (req),
        .ack   (ack)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        if (err_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Full sequence with one mapping and size, start retried while busy
    task automatic run_init(input logic map, input logic [2:0] shift, input logic slw);
        logic [31:0] cfg;
        int          n;
        int          sh;
        cfg = map ? (sdram_init_pkg::CFG_ROW_MAP | sdram_init_pkg::CFG_BANK_MAP_BIT)
                  : sdram_init_pkg::CFG_ROW_MAP;
        sh = (map ? sdram_init_pkg::BANK_SHIFT_MIN : sdram_init_pkg::ROW_SHIFT_MIN) + int'(shift);
        exp_o = '{sdram_init_pkg::CONTROL_OFS, sdram_init_pkg::CONFIG_OFS,
                  sdram_init_pkg::DYN_CONTROL_OFS, sdram_init_pkg::DYN_CFG_OFS,
                  sdram_init_pkg::DYN_CONTROL_OFS, sdram_init_pkg::DYN_CONTROL_OFS,
                  sdram_init_pkg::DYN_REFRESH_OFS, sdram_init_pkg::DYN_REFRESH_OFS,
                  sdram_init_pkg::RAS_CAS_OFS, sdram_init_pkg::DYN_CFG_OFS,
                  sdram_init_pkg::DYN_CONTROL_OFS, 12'h000,
                  sdram_init_pkg::DYN_CONTROL_OFS, sdram_init_pkg::DYN_CFG_OFS};
        exp_d = '{sdram_init_pkg::CONTROL_ENABLE, sdram_init_pkg::CONFIG_NORMAL,
                  sdram_init_pkg::DYN_CE_HIGH, sdram_init_pkg::CFG_BUF_OFF,
                  sdram_init_pkg::DYN_NOP, sdram_init_pkg::DYN_PRECHARGE,
                  sdram_init_pkg::REFRESH_MIN, {16'h0000, refresh_value},
                  {16'h0000, ras_cas_value}, cfg, sdram_init_pkg::DYN_MODE,
                  sdram_init_pkg::SDRAM_BASE + ({24'h000000, sdram_init_pkg::MODE_VALUE} << sh),
                  sdram_init_pkg::DYN_NORMAL, cfg | sdram_init_pkg::CFG_ROW_MAP_ON};
        bank_row_col_map = map;
        size_shift = shift;
        slow = slw;
        M.log_q.delete();
        M.cyc_q.delete();
        M.refs_q.delete();
        start = 1'b1;
        step(1);
        start = 1'b0;
        step(2);
        check_flag(busy, 1'b1);
        check_flag(ce_forced, 1'b1);
        // Retry while busy must not restart the sequence
        start = 1'b1;
        step(1);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 5000) begin
            step(1);
            n++;
        end
        check_flag(done, 1'b1);
        check_flag(busy, 1'b0);
        check_flag(ce_forced, 1'b0);
        check_word(32'(M.log_q.size()), 32'd14);
        if (M.log_q.size() == 14) begin
            for (int i = 0; i < 14; i++) begin
                check_flag(M.log_q[i].write, i != 11);
                if (i == 11) check_word(M.log_q[i].addr, exp_d[11]);
                else check_word(M.log_q[i].addr, {20'h00000, exp_o[i]});
                if (i != 11) check_word(M.log_q[i].data, exp_d[i]);
            end
            check_flag(M.cyc_q[4] - M.cyc_q[3] >= PWR, 1'b1);
            check_flag(M.refs_q[7] - M.refs_q[6] >= sdram_init_pkg::MIN_REFRESHES, 1'b1);
            check_word(M.mode_addr, exp_d[11] - sdram_init_pkg::SDRAM_BASE);
        end
    endtask

    // Reset in mid-run must drop every output
    task automatic reset_mid_run;
        start = 1'b1;
        step(1);
        start = 1'b0;
        step(5);
        rst = 1'b1;
        step(2);
        check_flag(req.valid, 1'b0);
        check_flag(busy, 1'b0);
        check_flag(done, 1'b0);
        check_flag(ce_forced, 1'b0);
        rst = 1'b0;
        step(1);
    endtask

    initial begin
        err_count = 0;
        total_checks = 0;
        rst = 1'b1;
        start = 1'b0;
        bank_row_col_map = 1'b0;
        size_shift = 3'h0;
        refresh_value = 16'h000b;
        ras_cas_value = 16'h0202;
        slow = 1'b0;
        step(16);
        rst = 1'b0;
        run_init(1'b0, 3'h0, 1'b0);
        run_init(1'b0, 3'h4, 1'b1);
        run_init(1'b1, 3'h0, 1'b0);
        reset_mid_run();
        refresh_value = 16'h0001;
        run_init(1'b1, 3'h3, 1'b1);
        give_verdict();
    end

    // Whole run needs well under a thousand cycles per sequence
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        give_verdict();
    end
endmodule // test_sdram_init_sequencer
